// ### rtl/bci_core.sv
/*
  Bus-cycle sequencer of an 8-bit processor front end: fetch with refresh,
  memory and I/O reads and writes, interrupt acknowledge, bus grant, halt.
  Assumes an execution core issues machine cycles on the request port and
  that all pins are synchronous to i_clock; each T state is one clock.
*/
`timescale 1ns/1ps
`include "bci_cfg.svh"
module bci_core
  import bci_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_nonmaskable_irq_n,
  input wire logic i_maskable_irq_n,
  input wire logic i_wait_n,
  input wire logic i_bus_request_n,
  input wire logic [7:0] i_data,
  input wire logic i_cyc_valid,
  input wire bci_cycle_type i_cyc_kind,
  input wire logic [15:0] i_cyc_addr,
  input wire logic [7:0] i_cyc_wdata,
  input wire logic i_cyc_last,
  input wire logic i_pc_load,
  input wire logic [15:0] i_pc_value,
  input wire logic i_vector_base_we,
  input wire logic [7:0] i_vector_base,
  input wire logic i_irq_enable_set,
  input wire logic i_irq_enable_clear,
  input wire logic i_mode_we,
  input wire bci_imode_type i_mode,
  input wire logic i_halt_exec,
  output logic [15:0] o_addr,
  output logic o_addr_oe,
  output logic [7:0] o_data,
  output logic o_data_oe,
  output logic o_ctrl_oe,
  output logic o_mem_request_n,
  output logic o_io_request_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_first_cycle_n,
  output logic o_refresh_strobe_n,
  output logic o_halt_n,
  output logic o_bus_grant_n,
  output logic o_cyc_ready,
  output logic o_cyc_done,
  output logic [7:0] o_cyc_rdata,
  output logic o_svc_valid,
  output logic o_svc_nmi,
  output logic [15:0] o_svc_addr,
  output logic [15:0] o_pc,
  output logic o_irq_enable,
  output bci_imode_type o_irq_mode
);

  bci_irq_if ifc ();
  bci_core_state_type r_reg;
  bci_core_state_type r_next;

  logic long_kind;
  logic last_state;
  logic decide;
  logic int_window;
  logic nk_fetchlike;
  logic nk_mem;
  logic nk_io;
  logic nk_write;
  logic ph_t2w;
  logic ph_t23;
  logic refresh_on;

  bci_irq_ctl bci_irq_ctl_inst (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_nonmaskable_irq_n(i_nonmaskable_irq_n),
    .i_maskable_irq_n(i_maskable_irq_n),
    .i_irq_enable_set(i_irq_enable_set),
    .i_irq_enable_clear(i_irq_enable_clear),
    .i_mode_we(i_mode_we),
    .i_mode(i_mode),
    .ifc(ifc.ctl)
  );

  // Fetch, nonmaskable and acknowledge cycles end in T4, the last refresh state
  assign long_kind = (r_reg.kind == CYC_FETCH) | (r_reg.kind == CYC_NMI)
    | (r_reg.kind == CYC_INTA);
  assign last_state = (r_reg.phase == PH_T4) | ((r_reg.phase == PH_T3) & ~long_kind);
  assign decide = last_state | (r_reg.phase == PH_IDLE);
  // Idle between instructions keeps the sampling point open
  assign int_window = last_state ? r_reg.last_instr : (decide & r_reg.boundary);

  always_comb
  begin
    r_next = r_reg;
    r_next.ready = 1'b0;
    r_next.done = 1'b0;
    r_next.svc_valid = 1'b0;
    ifc.accept_nmi = 1'b0;
    ifc.accept_int = 1'b0;
    if (i_halt_exec)
    begin
      r_next.halted = 1'b1;
    end
    if (i_pc_load)
    begin
      r_next.pc = i_pc_value;
    end
    if (i_vector_base_we)
    begin
      r_next.vector_base = i_vector_base;
    end
    case (r_reg.phase)
      PH_T1:
      begin
        r_next.phase = PH_T2;
      end
      PH_T2, PH_TW:
      begin
        if (!i_wait_n)
        begin
          r_next.phase = PH_TW;
        end
        else if (r_reg.auto_wait != 2'h0)
        begin
          r_next.phase = PH_TWA;
        end
        else
        begin
          r_next.phase = PH_T3;
        end
      end
      PH_TWA:
      begin
        r_next.auto_wait = r_reg.auto_wait - 2'h1;
        if (r_reg.auto_wait == 2'h1)
        begin
          r_next.phase = PH_T3;
        end
      end
      PH_T3:
      begin
        if (long_kind)
        begin
          r_next.phase = PH_T4;
        end
      end
      PH_T4:
      begin
        r_next.phase = PH_T4;
      end
      PH_GRANT:
      begin
        if (i_bus_request_n)
        begin
          r_next.phase = PH_IDLE;
        end
      end
      PH_IDLE:
      begin
        r_next.phase = PH_IDLE;
      end
      default:
      begin
        r_next.phase = PH_IDLE;
      end
    endcase
    if ((r_next.phase == PH_T3) && (r_reg.phase != PH_T3))
    begin
      r_next.rdata = i_data;
    end
    if (last_state)
    begin
      if (long_kind)
      begin
        r_next.refresh = r_reg.refresh + 7'h01;
      end
      r_next.boundary = 1'b0;
      case (r_reg.kind)
        CYC_NMI:
        begin
          // Fetched byte is dropped; restart goes to the fixed address
          r_next.pc = `BCI_NMI_ADDR;
          r_next.svc_valid = 1'b1;
          r_next.svc_nmi = 1'b1;
          r_next.svc_addr = `BCI_NMI_ADDR;
        end
        CYC_INTA:
        begin
          r_next.svc_valid = 1'b1;
          r_next.svc_nmi = 1'b0;
          r_next.done_data = r_reg.rdata;
          case (ifc.mode)
            IM_1:
            begin
              r_next.pc = `BCI_MODE1_ADDR;
              r_next.svc_addr = `BCI_MODE1_ADDR;
            end
            IM_2:
            begin
              r_next.svc_addr = {r_reg.vector_base, r_reg.rdata};
            end
            default:
            begin
              r_next.svc_addr = {8'h00, r_reg.rdata};
            end
          endcase
        end
        default:
        begin
          r_next.done = 1'b1;
          r_next.done_data = r_reg.rdata;
          r_next.boundary = r_reg.last_instr;
        end
      endcase
      r_next.phase = PH_IDLE;
    end
    if (decide)
    begin
      if (!i_bus_request_n)
      begin
        // Interrupts stay unconsumed and are looked at again after the grant
        r_next.phase = PH_GRANT;
        if (int_window)
        begin
          r_next.boundary = 1'b1;
        end
      end
      else if (int_window & (ifc.take_nmi | ifc.take_int))
      begin
        r_next.phase = PH_T1;
        r_next.halted = 1'b0;
        r_next.last_instr = 1'b0;
        r_next.boundary = 1'b0;
        r_next.cyc_addr = r_reg.pc;
        if (ifc.take_nmi)
        begin
          ifc.accept_nmi = 1'b1;
          r_next.kind = CYC_NMI;
          r_next.auto_wait = 2'h0;
        end
        else
        begin
          ifc.accept_int = 1'b1;
          r_next.kind = CYC_INTA;
          r_next.auto_wait = `BCI_INTA_WAITS;
        end
      end
      else if (r_next.halted)
      begin
        // No-op fetch at a frozen address keeps refresh running
        r_next.phase = PH_T1;
        r_next.kind = CYC_FETCH;
        r_next.cyc_addr = r_reg.pc;
        r_next.last_instr = 1'b1;
        r_next.auto_wait = 2'h0;
      end
      else if (i_cyc_valid)
      begin
        r_next.ready = 1'b1;
        r_next.phase = PH_T1;
        r_next.last_instr = i_cyc_last;
        r_next.wdata = i_cyc_wdata;
        r_next.cyc_addr = i_cyc_addr;
        r_next.auto_wait = 2'h0;
        case (i_cyc_kind)
          CYC_MRD, CYC_MWR:
          begin
            r_next.kind = i_cyc_kind;
          end
          CYC_IORD, CYC_IOWR:
          begin
            r_next.kind = i_cyc_kind;
            r_next.auto_wait = `BCI_IO_WAITS;
          end
          default:
          begin
            r_next.kind = CYC_FETCH;
            r_next.cyc_addr = r_next.pc;
            r_next.pc = r_next.pc + 16'h0001;
          end
        endcase
      end
    end
    // Strobes are decoded from the next state so every pin leaves a flip-flop
    nk_fetchlike = (r_next.kind == CYC_FETCH) | (r_next.kind == CYC_NMI);
    nk_mem = (r_next.kind == CYC_MRD) | (r_next.kind == CYC_MWR);
    nk_io = (r_next.kind == CYC_IORD) | (r_next.kind == CYC_IOWR);
    nk_write = (r_next.kind == CYC_MWR) | (r_next.kind == CYC_IOWR);
    ph_t2w = (r_next.phase == PH_T2) | (r_next.phase == PH_TW) | (r_next.phase == PH_TWA);
    ph_t23 = ph_t2w | (r_next.phase == PH_T3);
    refresh_on = (nk_fetchlike & ((r_next.phase == PH_T3) | (r_next.phase == PH_T4)))
      | ((r_next.kind == CYC_INTA) & (r_next.phase == PH_T4));
    r_next.grant_n = r_next.phase != PH_GRANT;
    r_next.addr_oe = r_next.phase != PH_GRANT;
    r_next.ctrl_oe = r_next.phase != PH_GRANT;
    r_next.data_oe = nk_write & (ph_t23 | (r_next.phase == PH_T1));
    r_next.dout = r_next.wdata;
    r_next.addr = refresh_on ? {r_next.vector_base, `BCI_REFRESH_PAD, r_next.refresh}
      : r_next.cyc_addr;
    r_next.mem_request_n_n = ~((nk_mem & ph_t23) | (nk_fetchlike & ph_t2w) | refresh_on);
    r_next.refresh_strobe_n_n = ~refresh_on;
    r_next.rd_n = ~((nk_fetchlike & ph_t2w)
      | (((r_next.kind == CYC_MRD) | (r_next.kind == CYC_IORD)) & ph_t23));
    r_next.wr_n = ~(((r_next.kind == CYC_MWR) & ((r_next.phase == PH_TW)
      | (r_next.phase == PH_T3))) | ((r_next.kind == CYC_IOWR) & (ph_t23
      & (r_next.phase != PH_T2))));
    r_next.io_request_n_n = ~((nk_io & ph_t23) | ((r_next.kind == CYC_INTA)
      & (ph_t23 & (r_next.phase != PH_T2))));
    r_next.m1_n = ~((nk_fetchlike & ((r_next.phase == PH_T1) | ph_t2w))
      | ((r_next.kind == CYC_INTA) & ((r_next.phase == PH_T1) | ph_t23)));
    if (r_next.phase == PH_IDLE || r_next.phase == PH_GRANT)
    begin
      r_next.mem_request_n_n = 1'b1;
      r_next.rd_n = 1'b1;
      r_next.wr_n = 1'b1;
      r_next.io_request_n_n = 1'b1;
      r_next.m1_n = 1'b1;
      r_next.refresh_strobe_n_n = 1'b1;
      r_next.data_oe = 1'b0;
    end
    r_next.halt_n = ~r_next.halted;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      r_reg <= '0;
      r_reg.phase <= PH_IDLE;
      r_reg.kind <= CYC_FETCH;
      r_reg.boundary <= 1'b1;
      r_reg.pc <= `BCI_PC_RESET;
      r_reg.vector_base <= `BCI_VBASE_RESET;
      r_reg.refresh <= `BCI_REFRESH_RESET;
      r_reg.mem_request_n_n <= 1'b1;
      r_reg.io_request_n_n <= 1'b1;
      r_reg.rd_n <= 1'b1;
      r_reg.wr_n <= 1'b1;
      r_reg.m1_n <= 1'b1;
      r_reg.refresh_strobe_n_n <= 1'b1;
      r_reg.halt_n <= 1'b1;
      r_reg.grant_n <= 1'b1;
    end
    else if (i_clk_en)
    begin
      r_reg <= r_next;
    end
  end

  assign o_addr = r_reg.addr;
  assign o_addr_oe = r_reg.addr_oe;
  assign o_data = r_reg.dout;
  assign o_data_oe = r_reg.data_oe;
  assign o_ctrl_oe = r_reg.ctrl_oe;
  assign o_mem_request_n = r_reg.mem_request_n_n;
  assign o_io_request_n = r_reg.io_request_n_n;
  assign o_rd_n = r_reg.rd_n;
  assign o_wr_n = r_reg.wr_n;
  assign o_first_cycle_n = r_reg.m1_n;
  assign o_refresh_strobe_n = r_reg.refresh_strobe_n_n;
  assign o_halt_n = r_reg.halt_n;
  assign o_bus_grant_n = r_reg.grant_n;
  assign o_cyc_ready = r_reg.ready;
  assign o_cyc_done = r_reg.done;
  assign o_cyc_rdata = r_reg.done_data;
  assign o_svc_valid = r_reg.svc_valid;
  assign o_svc_nmi = r_reg.svc_nmi;
  assign o_svc_addr = r_reg.svc_addr;
  assign o_pc = r_reg.pc;
  assign o_irq_enable = ifc.irq_enable;
  assign o_irq_mode = ifc.mode;

endmodule

// ### rtl/bci_cfg.svh
/*
  Constants of the bus-cycle and interrupt front end: restart addresses,
  automatic wait counts and reset values.
  Assumes inclusion by bare name from the design files.
*/
`ifndef BCI_CFG_SVH
`define BCI_CFG_SVH

`define BCI_PC_RESET 16'h0000
`define BCI_NMI_ADDR 16'h0066
`define BCI_MODE1_ADDR 16'h0038
`define BCI_IO_WAITS 2'h1
`define BCI_INTA_WAITS 2'h2
`define BCI_VBASE_RESET 8'h00
`define BCI_REFRESH_RESET 7'h00
`define BCI_REFRESH_PAD 1'h0

`endif

// ### rtl/bci_pkg.sv
/*
  Types of the bus-cycle and interrupt front end: cycle phases, cycle kinds,
  interrupt modes and the state records of both modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package bci_pkg;

  typedef enum logic [7:0] {
    PH_IDLE = 8'h01,
    PH_T1 = 8'h02,
    PH_T2 = 8'h04,
    PH_TW = 8'h08,
    PH_TWA = 8'h10,
    PH_T3 = 8'h20,
    PH_T4 = 8'h40,
    PH_GRANT = 8'h80
  } bci_phase_type;

  typedef enum logic [6:0] {
    CYC_FETCH = 7'h01,
    CYC_MRD = 7'h02,
    CYC_MWR = 7'h04,
    CYC_IORD = 7'h08,
    CYC_IOWR = 7'h10,
    CYC_INTA = 7'h20,
    CYC_NMI = 7'h40
  } bci_cycle_type;

  typedef enum logic [1:0] {
    IM_0 = 2'h0,
    IM_1 = 2'h1,
    IM_2 = 2'h2
  } bci_imode_type;

  typedef struct packed {
    logic nmi_prev;
    logic nmi_pend;
    logic irq_enable_ff;
    bci_imode_type mode;
  } bci_irq_state_type;

  typedef struct packed {
    bci_phase_type phase;
    bci_cycle_type kind;
    logic last_instr;
    logic boundary;
    logic halted;
    logic [1:0] auto_wait;
    logic [15:0] pc;
    logic [7:0] vector_base;
    logic [6:0] refresh;
    logic [15:0] cyc_addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [15:0] addr;
    logic addr_oe;
    logic [7:0] dout;
    logic data_oe;
    logic ctrl_oe;
    logic mem_request_n_n;
    logic io_request_n_n;
    logic rd_n;
    logic wr_n;
    logic m1_n;
    logic refresh_strobe_n_n;
    logic halt_n;
    logic grant_n;
    logic ready;
    logic done;
    logic [7:0] done_data;
    logic svc_valid;
    logic svc_nmi;
    logic [15:0] svc_addr;
  } bci_core_state_type;

endpackage

// ### rtl/bci_irq_if.sv
/*
  Link between the cycle sequencer and the interrupt controller.
  Assumes both ends run on the same clock and clock enable.
*/
`timescale 1ns/1ps
interface bci_irq_if;
  import bci_pkg::*;
  logic take_nmi;
  logic take_int;
  logic accept_nmi;
  logic accept_int;
  logic irq_enable;
  bci_imode_type mode;

  modport core (input take_nmi, input take_int, input irq_enable, input mode,
    output accept_nmi, output accept_int);
  modport ctl (output take_nmi, output take_int, output irq_enable, output mode,
    input accept_nmi, input accept_int);
endinterface

// ### rtl/bci_irq_ctl.sv
/*
  Interrupt controller: nonmaskable edge catch, enable flip-flop, mode.
  Assumes interrupt pins are synchronous to i_clock.
*/
`timescale 1ns/1ps
`include "bci_cfg.svh"
module bci_irq_ctl
  import bci_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_clk_en,
  input wire logic i_nonmaskable_irq_n,
  input wire logic i_maskable_irq_n,
  input wire logic i_irq_enable_set,
  input wire logic i_irq_enable_clear,
  input wire logic i_mode_we,
  input wire bci_imode_type i_mode,
  bci_irq_if.ctl ifc
);

  bci_irq_state_type r_reg;
  bci_irq_state_type r_next;
  logic nmi_fall;

  assign nmi_fall = r_reg.nmi_prev & ~i_nonmaskable_irq_n;
  // Pending edge or an edge seen right at the sampling edge both count
  assign ifc.take_nmi = r_reg.nmi_pend | nmi_fall;
  assign ifc.take_int = ~ifc.take_nmi & ~i_maskable_irq_n & r_reg.irq_enable_ff;
  assign ifc.irq_enable = r_reg.irq_enable_ff;
  assign ifc.mode = r_reg.mode;

  always_comb
  begin
    r_next = r_reg;
    r_next.nmi_prev = i_nonmaskable_irq_n;
    if (i_mode_we)
    begin
      r_next.mode = i_mode;
    end
    if (i_irq_enable_set)
    begin
      r_next.irq_enable_ff = 1'b1;
    end
    if (i_irq_enable_clear | ifc.accept_int | ifc.accept_nmi)
    begin
      r_next.irq_enable_ff = 1'b0;
    end
    // A new edge in the accept cycle stays pending
    r_next.nmi_pend = (r_reg.nmi_pend & ~ifc.accept_nmi) | nmi_fall;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_rst)
    begin
      r_reg.nmi_prev <= 1'b1;
      r_reg.nmi_pend <= 1'b0;
      r_reg.irq_enable_ff <= 1'b0;
      r_reg.mode <= IM_0;
    end
    else if (i_clk_en)
    begin
      r_reg <= r_next;
    end
  end

endmodule

// ### verif/bci_core_asserts.sv
/*
  Checker of bci_core strobes, waits and bus grant.
  Assumes binding to bci_core; i_rst is synchronous, active high.
*/
`timescale 1ns/1ps
module bci_core_asserts
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_wait_n,
  input wire logic i_bus_request_n,
  input wire logic [15:0] o_addr,
  input wire logic o_addr_oe,
  input wire logic o_data_oe,
  input wire logic o_ctrl_oe,
  input wire logic o_mem_request_n,
  input wire logic o_io_request_n,
  input wire logic o_rd_n,
  input wire logic o_wr_n,
  input wire logic o_first_cycle_n,
  input wire logic o_refresh_strobe_n,
  input wire logic o_bus_grant_n
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // Auto waits are fixed, so the wait pin must not stretch them
  sequence seq_io_hold;
    !o_io_request_n [*3] ##1 o_io_request_n;
  endsequence
  sequence seq_refresh_end;
    !o_refresh_strobe_n ##1 o_refresh_strobe_n;
  endsequence
  AST_GRANT_FLOAT: assert property (
    !o_bus_grant_n |-> !o_addr_oe && !o_ctrl_oe && !o_data_oe)
    else $error("grant while bus driven");
  AST_GRANT_CAUSE: assert property (
    !o_bus_grant_n |-> $past(!i_bus_request_n))
    else $error("grant without request");
  AST_GRANT_RESUME: assert property (
    $rose(o_bus_grant_n) |-> o_addr_oe && o_ctrl_oe && $past(i_bus_request_n))
    else $error("bus not resumed with grant release");
  AST_REFRESH_MEM_REQUEST_N: assert property (
    !o_refresh_strobe_n |-> !o_mem_request_n && o_rd_n && !o_addr[7])
    else $error("refresh strobe without memory request");
  AST_FETCH_REFRESH: assert property (
    $fell(o_refresh_strobe_n) && $past(!o_mem_request_n) |-> ##1 seq_refresh_end)
    else $error("fetch refresh not two states");
  AST_IO_AUTOWAIT: assert property (
    $fell(o_io_request_n) && o_first_cycle_n && i_wait_n |-> seq_io_hold)
    else $error("io cycle length wrong");
  AST_ACK_WAITS: assert property (
    $fell(o_io_request_n) && !o_first_cycle_n |-> seq_io_hold)
    else $error("acknowledge waits wrong");
  AST_ACK_PAIR: assert property (
    !o_first_cycle_n && !o_io_request_n |-> o_mem_request_n && $past(!o_first_cycle_n, 2))
    else $error("acknowledge marker wrong");
  AST_IO_ADDR: assert property (
    !o_io_request_n && o_first_cycle_n |-> o_mem_request_n && o_addr_oe && $stable(o_addr))
    else $error("io request without stable port address");
  AST_WR_STABLE: assert property (
    $fell(o_wr_n) && !o_mem_request_n |-> $past(!o_mem_request_n) && $past(o_data_oe, 2))
    else $error("write strobe before data stable");
  AST_WAIT_STRETCH: assert property (
    $fell(o_rd_n) && !o_mem_request_n && o_first_cycle_n && !i_wait_n |=> !o_rd_n [*2])
    else $error("wait state not inserted");
endmodule

bind bci_core bci_core_asserts bci_core_asserts_inst (.i_clock, .i_rst, .i_wait_n,
  .i_bus_request_n, .o_addr, .o_addr_oe, .o_data_oe, .o_ctrl_oe, .o_mem_request_n,
  .o_io_request_n, .o_rd_n, .o_wr_n, .o_first_cycle_n, .o_refresh_strobe_n, .o_bus_grant_n);

// ### verif/bci_mem_model.sv
/*
  Memory, port and interrupter model for bci_core.
  Assumes strobes synchronous to i_clock; i_slow asks two wait states.
*/
`timescale 1ns/1ps
module bci_mem_model
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_slow,
  input wire logic [15:0] i_addr,
  input wire logic i_mem_request_n,
  input wire logic i_io_request_n,
  input wire logic i_rd_n,
  input wire logic i_first_cycle_n,
  input wire logic i_refresh_strobe_n,
  output logic o_wait_n,
  output logic [7:0] o_data
);
  logic [7:0] last_reg;
  logic [1:0] cnt_reg;
  logic strobe;
  assign strobe = (!i_mem_request_n || !i_io_request_n) && i_first_cycle_n && i_refresh_strobe_n;
  always_ff @(posedge i_clock)
  begin
    last_reg <= o_data;
    if (i_rst || !strobe)
      cnt_reg <= 2'h0;
    else if (cnt_reg != 2'h3)
      cnt_reg <= cnt_reg + 2'h1;
  end
  assign o_wait_n = !(i_slow && strobe && cnt_reg < 2'h2);
  // Undriven bus toggles so a late latch cannot pass by luck
  always_comb
  begin
    if (!i_first_cycle_n && !i_io_request_n)
      o_data = 8'h5a;
    else if (!i_rd_n && !i_mem_request_n)
      o_data = i_addr[7:0] ^ 8'ha5;
    else if (!i_rd_n && !i_io_request_n)
      o_data = i_addr[7:0] ^ 8'h3c;
    else
      o_data = ~last_reg;
  end
endmodule

// ### verif/bci_core_test.sv
/*
  Self-checking bench of bci_core with a memory and port model.
  Assumes a 100 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module bci_core_test;
  import bci_pkg::*;
  logic i_clock = 1'b0, i_rst = 1'b1, i_clk_en = 1'b1, slow = 1'b0;
  logic i_nonmaskable_irq_n = 1'b1, i_maskable_irq_n = 1'b1, i_bus_request_n = 1'b1;
  logic i_cyc_valid = 1'b0, i_cyc_last = 1'b0, i_pc_load = 1'b0, i_vector_base_we = 1'b0;
  logic i_irq_enable_set = 1'b0, i_irq_enable_clear = 1'b0, i_mode_we = 1'b0;
  logic i_halt_exec = 1'b0, i_wait_n;
  bci_cycle_type i_cyc_kind = CYC_FETCH;
  bci_imode_type i_mode = IM_0;
  bci_imode_type o_irq_mode;
  logic [15:0] i_cyc_addr = 16'h0000, i_pc_value = 16'h0000;
  logic [7:0] i_cyc_wdata = 8'h00, i_vector_base = 8'h00, i_data, o_data, o_cyc_rdata;
  logic [15:0] o_addr, o_svc_addr, o_pc;
  logic o_addr_oe, o_data_oe, o_ctrl_oe, o_mem_request_n, o_io_request_n, o_rd_n, o_wr_n;
  logic o_first_cycle_n, o_refresh_strobe_n, o_halt_n, o_bus_grant_n, o_cyc_ready;
  logic o_cyc_done, o_svc_valid, o_svc_nmi, o_irq_enable;
  int failures = 0;
  int samples_checked = 0;

  bci_core bci_core_inst (.i_clock, .i_rst, .i_clk_en, .i_nonmaskable_irq_n, .i_maskable_irq_n,
    .i_wait_n, .i_bus_request_n, .i_data, .i_cyc_valid, .i_cyc_kind, .i_cyc_addr, .i_cyc_wdata,
    .i_cyc_last, .i_pc_load, .i_pc_value, .i_vector_base_we, .i_vector_base, .i_irq_enable_set,
    .i_irq_enable_clear, .i_mode_we, .i_mode, .i_halt_exec, .o_addr, .o_addr_oe, .o_data,
    .o_data_oe, .o_ctrl_oe, .o_mem_request_n, .o_io_request_n, .o_rd_n, .o_wr_n,
    .o_first_cycle_n, .o_refresh_strobe_n, .o_halt_n, .o_bus_grant_n, .o_cyc_ready, .o_cyc_done,
    .o_cyc_rdata, .o_svc_valid, .o_svc_nmi, .o_svc_addr, .o_pc, .o_irq_enable, .o_irq_mode);
  bci_mem_model bci_mem_model_inst (.i_clock, .i_rst, .i_slow(slow), .i_addr(o_addr),
    .i_mem_request_n(o_mem_request_n), .i_io_request_n(o_io_request_n), .i_rd_n(o_rd_n),
    .i_first_cycle_n(o_first_cycle_n), .i_refresh_strobe_n(o_refresh_strobe_n),
    .o_wait_n(i_wait_n), .o_data(i_data));

  always #5 i_clock = ~i_clock;

  task automatic print_verdict;
    if (failures == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic time_out;
    failures++;
    $display("MISMATCH %0t wait bound used up", $time);
    print_verdict();
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // Interrupt lines change only once the cycle is taken, so none hits an idle boundary
  task automatic run_cycle(input bci_cycle_type k, input logic [15:0] a, input logic last,
      input logic [1:0] irq_n, output logic [7:0] rd, output logic [15:0] rf, output int len);
    int n;
    rf = 16'hffff;
    @(posedge i_clock);
    i_cyc_valid <= 1'b1;
    i_cyc_kind <= k;
    i_cyc_addr <= a;
    i_cyc_wdata <= a[15:8];
    i_cyc_last <= last;
    for (n = 0; n < 20 && o_cyc_ready !== 1'b1; n++)
      @(negedge i_clock);
    if (n == 20)
      time_out();
    @(posedge i_clock);
    i_cyc_valid <= 1'b0;
    {i_nonmaskable_irq_n, i_maskable_irq_n} <= irq_n;
    for (len = 0; len < 20 && o_cyc_done !== 1'b1; len++)
    begin
      @(negedge i_clock);
      if (o_refresh_strobe_n === 1'b0)
        rf = o_addr;
      else if (o_wr_n === 1'b0 && o_data_oe === 1'b1)
        rf = 16'(o_data);
    end
    if (len == 20)
      time_out();
    rd = o_cyc_rdata;
  endtask
  task automatic wait_svc(output logic seen);
    seen = 1'b0;
    for (int n = 0; n < 16 && !seen; n++)
    begin
      @(negedge i_clock);
      seen = (o_svc_valid === 1'b1);
    end
  endtask
  task automatic t_reset;
    @(posedge i_clock);
    i_rst <= 1'b1;
    repeat (20) @(negedge i_clock);
    cmp(16'({o_addr_oe, o_ctrl_oe, o_data_oe}), 16'h0000, "bus floats");
    cmp(16'({o_mem_request_n, o_io_request_n, o_rd_n, o_wr_n, o_first_cycle_n,
      o_refresh_strobe_n, o_halt_n, o_bus_grant_n}), 16'h00ff, "strobes idle");
    @(posedge i_clock);
    i_rst <= 1'b0;
    @(negedge i_clock);
    cmp(o_pc, 16'h0000, "pc cleared");
    cmp(16'({o_irq_enable, o_irq_mode}), 16'h0000, "irq state cleared");
  endtask
  task automatic t_fetch;
    logic [7:0] d;
    logic [15:0] rf;
    int len;
    @(posedge i_clock);
    i_pc_load <= 1'b1;
    i_pc_value <= 16'h1230;
    @(posedge i_clock);
    i_pc_load <= 1'b0;
    for (int i = 0; i < 2; i++)
    begin
      run_cycle(CYC_FETCH, 16'h0000, 1'b0, 2'b11, d, rf, len);
      cmp(16'(d), 16'(8'(8'h30 + i) ^ 8'ha5), "fetch data");
      cmp(rf, 16'(i), "refresh address");
      cmp(16'(len), 16'h0004, "fetch length");
    end
    cmp(o_pc, 16'h1232, "pc advanced");
  endtask
  task automatic t_cycles;
    bci_cycle_type k[6] = '{CYC_MRD, CYC_MWR, CYC_IORD, CYC_IOWR, CYC_MRD, CYC_IORD};
    int exp_len[6] = '{3, 3, 4, 4, 5, 6};
    logic [7:0] d;
    logic [15:0] rf;
    int len;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge i_clock);
      slow <= (i > 3);
      run_cycle(k[i], 16'h4400 + 16'(i), 1'b0, 2'b11, d, rf, len);
      cmp(16'(len), 16'(exp_len[i]), "cycle length");
      cmp((k[i][2] | k[i][4]) ? rf : 16'(d), (k[i][2] | k[i][4]) ? 16'h0044
        : 16'(8'(i) ^ (k[i] == CYC_MRD ? 8'ha5 : 8'h3c)), "bus data");
    end
    slow <= 1'b0;
  endtask
  task automatic t_irq;
    bci_imode_type m[3] = '{IM_0, IM_1, IM_2};
    logic [15:0] exp[3] = '{16'h005a, 16'h0038, 16'h9c5a};
    logic [7:0] d;
    logic [15:0] rf;
    int len;
    logic seen;
    for (int i = 0; i < 3; i++)
    begin
      @(posedge i_clock);
      i_vector_base <= 8'h9c;
      i_vector_base_we <= 1'b1;
      i_mode <= m[i];
      i_mode_we <= 1'b1;
      i_irq_enable_set <= 1'b1;
      @(posedge i_clock);
      {i_vector_base_we, i_mode_we, i_irq_enable_set} <= 3'h0;
      run_cycle(CYC_FETCH, 16'h0000, 1'b1, 2'b10, d, rf, len);
      wait_svc(seen);
      cmp(16'(seen), 16'h0001, "interrupt taken");
      cmp(o_svc_addr, exp[i], "service address");
      cmp(16'({o_cyc_rdata, o_irq_enable}), 16'h00b4, "vector and enable");
      @(posedge i_clock);
      i_maskable_irq_n <= 1'b1;
    end
    @(posedge i_clock);
    i_irq_enable_set <= 1'b1;
    @(posedge i_clock);
    i_irq_enable_set <= 1'b0;
    run_cycle(CYC_FETCH, 16'h0000, 1'b0, 2'b10, d, rf, len);
    wait_svc(seen);
    cmp(16'(seen), 16'h0000, "taken inside instruction");
    @(posedge i_clock);
    i_irq_enable_clear <= 1'b1;
    @(posedge i_clock);
    i_irq_enable_clear <= 1'b0;
    run_cycle(CYC_FETCH, 16'h0000, 1'b1, 2'b10, d, rf, len);
    wait_svc(seen);
    cmp(16'(seen), 16'h0000, "taken while disabled");
    @(posedge i_clock);
    i_irq_enable_set <= 1'b1;
    i_maskable_irq_n <= 1'b1;
    @(posedge i_clock);
    i_irq_enable_set <= 1'b0;
    run_cycle(CYC_FETCH, 16'h0000, 1'b1, 2'b00, d, rf, len);
    wait_svc(seen);
    cmp(16'({seen, o_svc_nmi}), 16'h0003, "nonmaskable first");
    cmp(o_svc_addr, 16'h0066, "nonmaskable address");
    cmp(o_pc, 16'h0066, "restart pc");
    @(posedge i_clock);
    {i_nonmaskable_irq_n, i_maskable_irq_n} <= 2'b11;
  endtask
  task automatic release_bus;
    @(posedge i_clock);
    i_bus_request_n <= 1'b1;
    repeat (2) @(negedge i_clock);
    cmp(16'({o_bus_grant_n, o_addr_oe, o_ctrl_oe}), 16'h0007, "bus resumed");
  endtask
  task automatic t_bus;
    logic [7:0] d;
    logic [15:0] rf;
    int len;
    int n;
    @(posedge i_clock);
    i_bus_request_n <= 1'b0;
    for (n = 0; n < 8 && o_bus_grant_n !== 1'b0; n++)
      @(negedge i_clock);
    if (n == 8)
      time_out();
    cmp(16'({o_addr_oe, o_ctrl_oe, o_data_oe}), 16'h0000, "bus floated");
    release_bus();
    fork
      run_cycle(CYC_MRD, 16'h2000, 1'b0, 2'b11, d, rf, len);
      begin
        for (int j = 0; j < 20 && o_cyc_ready !== 1'b1; j++)
          @(negedge i_clock);
        @(posedge i_clock);
        i_bus_request_n <= 1'b0;
        repeat (2) @(negedge i_clock);
        cmp(16'(o_bus_grant_n), 16'h0001, "grant inside cycle");
      end
    join
    cmp(16'(o_bus_grant_n), 16'h0000, "grant at cycle end");
    release_bus();
  endtask
  task automatic t_halt;
    logic seen;
    logic prev;
    int falls;
    logic [15:0] pc0;
    pc0 = o_pc;
    falls = 0;
    prev = 1'b1;
    @(posedge i_clock);
    i_halt_exec <= 1'b1;
    @(posedge i_clock);
    i_halt_exec <= 1'b0;
    @(negedge i_clock);
    cmp(16'(o_halt_n), 16'h0000, "halt shown");
    repeat (20)
    begin
      @(negedge i_clock);
      falls += (prev && !o_first_cycle_n) ? 1 : 0;
      prev = o_first_cycle_n;
    end
    cmp(16'(falls >= 3), 16'h0001, "no-op fetches");
    cmp(o_pc, pc0, "pc held");
    @(posedge i_clock);
    i_nonmaskable_irq_n <= 1'b0;
    wait_svc(seen);
    cmp(16'({seen, o_halt_n}), 16'h0003, "halt ended");
    @(posedge i_clock);
    i_nonmaskable_irq_n <= 1'b1;
  endtask

  initial
  begin
    t_reset();
    t_fetch();
    t_cycles();
    t_irq();
    t_bus();
    t_halt();
    t_reset();
    t_fetch();
    print_verdict();
  end
endmodule
